// File: design/pndr_pattern_next_data_regs.sv
// Next-data register bank, port A/B output data, direction and transfer logic.
// Assumes a Wishbone classic master on mclk and compare-match strobes from the
// timer unit that are one-cycle pulses synchronous to mclk.
// Summary of operation
// RULE1: port B direction is 8-bit write-only; it enables pattern pins 15..8.
// RULE2: software sets direction bits for pins used as pattern outputs.
// RULE3: port B output data holds output values for groups 2 and 3.
// RULE4: port B data bits enabled by high enable are read-only to software.
// RULE5: selected compare-match copies low next-data bits into port A data.
// RULE6: selected compare-match copies high next-data bits into port B data.
// RULE7: low next-data byte resets to zero, kept through software standby.
// RULE8: high next-data byte resets to zero, kept through software standby.
// RULE9: groups 0/1 shared trigger: whole low byte at first address; second reads ones.
// RULE10: groups 0/1 split: group 1 upper first address, group 0 lower second.
// RULE11: groups 2/3 shared trigger: whole high byte at first address; second reads ones.
// RULE12: groups 2/3 split: group 3 upper first address, group 2 lower second.
// RULE13: low enable bit one lets compare-match copy; zero leaves output unchanged.
// RULE14: low enable register is 8-bit read/write, resets to zero.
// RULE15: high enable bits gate the copy to port B data the same way.
// RULE16: two-bit select per group picks one of four channels; reset to channel 3.
// RULE17: port A data bits enabled by low enable are read-only to software.
// RULE18: equal select fields mean shared trigger; each nibble moves on its own channel.
`timescale 1ns/1ps
module pndr_pattern_next_data_regs
   import pndr_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [17:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic [3:0] compareMatch,
   output logic [15:0] patternOut,
   output logic [7:0] portBOutEnableN,
   output logic [7:0] portAOutputData,
   output logic [7:0] portBOutputData
);

   // ******************************************************
   // Storage
   // ******************************************************
   logic [7:0] nextDataLowByte;
   logic [7:0] nextDataHighByte;
   logic [7:0] nextEnableLowByte;
   logic [7:0] nextEnableHighByte;
   logic [7:0] triggerSelectControl;
   logic [7:0] portBDirection;
   logic [3:0] groupFire;
   logic sameTrigLow;
   logic sameTrigHigh;
   logic [15:0] regIdx;
   logic access;
   logic wr;
   logic [7:0] wdat;
   logic [7:0] next_rdat;

   // Channel picked by a group's select field
   function automatic logic selFire(input logic [1:0] sel, input logic [3:0] cm);
      selFire = cm[sel];
   endfunction

   // Byte merge keeping protected bits
   function automatic logic [7:0] mergeProt(input logic [7:0] cur, input logic [7:0] nw,
                                            input logic [7:0] prot);
      mergeProt = (cur & prot) | (nw & ~prot);
   endfunction

   assign regIdx = wb_adr_i[17:ADDR_LSB];
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = access & wb_we_i & wb_sel_i[0];
   assign wdat = wb_dat_i[7:0];

   // Shared trigger when select fields are equal, see RULE18
   assign sameTrigLow = triggerSelectControl[1:0] == triggerSelectControl[3:2];
   assign sameTrigHigh = triggerSelectControl[5:4] == triggerSelectControl[7:6];

   // ******************************************************
   // Trigger decode per group
   // ******************************************************
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gFire
         assign groupFire[g] = selFire(triggerSelectControl[2*g+1:2*g], compareMatch); // see RULE16
      end
   endgenerate

   // ******************************************************
   // Bus acknowledge: one cycle after request, dropped next cycle
   // ******************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   // ******************************************************
   // Control registers
   // ******************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nextEnableLowByte <= RST_BYTE; // see RULE14
         nextEnableHighByte <= RST_BYTE;
         triggerSelectControl <= RST_TRIG_SELECT; // see RULE16
         portBDirection <= RST_BYTE;
      end else if (wr) begin
         if (regIdx == IDX_NEXT_EN_LOW) begin
            nextEnableLowByte <= wdat; // see RULE14
         end
         if (regIdx == IDX_NEXT_EN_HIGH) begin
            nextEnableHighByte <= wdat;
         end
         if (regIdx == IDX_TRIG_SELECT) begin
            triggerSelectControl <= wdat;
         end
         if (regIdx == IDX_PORT_B_DIR) begin
            portBDirection <= wdat; // see RULE1
         end
      end
   end

   // ******************************************************
   // Next-data low byte with address layout by trigger sharing
   // ******************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nextDataLowByte <= RST_BYTE; // see RULE7
      end else if (wr) begin
         if (regIdx == IDX_NDATA_LOW_MAIN) begin
            if (sameTrigLow) begin
               nextDataLowByte <= wdat; // see RULE9
            end else begin
               nextDataLowByte[7:4] <= wdat[7:4]; // see RULE10
            end
         end else if (regIdx == IDX_NDATA_LOW_SPLIT && !sameTrigLow) begin
            nextDataLowByte[3:0] <= wdat[3:0]; // see RULE10
         end
      end
   end

   // ******************************************************
   // Next-data high byte
   // ******************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nextDataHighByte <= RST_BYTE; // see RULE8
      end else if (wr) begin
         if (regIdx == IDX_NDATA_HIGH_MAIN) begin
            if (sameTrigHigh) begin
               nextDataHighByte <= wdat; // see RULE11
            end else begin
               nextDataHighByte[7:4] <= wdat[7:4]; // see RULE12
            end
         end else if (regIdx == IDX_NDATA_HIGH_SPLIT && !sameTrigHigh) begin
            nextDataHighByte[3:0] <= wdat[3:0]; // see RULE12
         end
      end
   end

   // ******************************************************
   // Port output data: CPU writes skip enabled bits; transfers win
   // ******************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         portAOutputData <= RST_BYTE;
      end else begin : pA
         logic [7:0] v;
         logic [7:0] moved;
         v = portAOutputData;
         if (wr && regIdx == IDX_PORT_A_DATA) begin
            v = mergeProt(v, wdat, nextEnableLowByte); // see RULE17
         end
         // Enabled bits take next data, disabled bits keep the port value
         moved = mergeProt(nextDataLowByte, v, nextEnableLowByte); // see RULE13
         // Each nibble moves on its own group's strobe, see RULE18
         if (groupFire[0]) begin
            v[3:0] = moved[3:0]; // see RULE5
         end
         if (groupFire[1]) begin
            v[7:4] = moved[7:4]; // see RULE5
         end
         portAOutputData <= v;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         portBOutputData <= RST_BYTE;
      end else begin : pB
         logic [7:0] v;
         logic [7:0] moved;
         v = portBOutputData;
         if (wr && regIdx == IDX_PORT_B_DATA) begin
            v = mergeProt(v, wdat, nextEnableHighByte); // see RULE4
         end
         moved = mergeProt(nextDataHighByte, v, nextEnableHighByte); // see RULE15
         if (groupFire[2]) begin
            v[3:0] = moved[3:0]; // see RULE6
         end
         if (groupFire[3]) begin
            v[7:4] = moved[7:4]; // see RULE6
         end
         portBOutputData <= v; // see RULE3
      end
   end

   // ******************************************************
   // Read path and pins
   // ******************************************************
   always_comb begin
      next_rdat = RST_BYTE;
      unique case (regIdx)
         IDX_NEXT_EN_LOW: next_rdat = nextEnableLowByte;
         IDX_NEXT_EN_HIGH: next_rdat = nextEnableHighByte;
         IDX_TRIG_SELECT: next_rdat = triggerSelectControl;
         IDX_PORT_A_DATA: next_rdat = portAOutputData;
         IDX_PORT_B_DATA: next_rdat = portBOutputData;
         IDX_NDATA_LOW_MAIN: next_rdat = sameTrigLow ? nextDataLowByte :
                                {nextDataLowByte[7:4], RESERVED_NIBBLE}; // see RULE10
         IDX_NDATA_LOW_SPLIT: next_rdat = sameTrigLow ? RESERVED_BYTE :
                                {RESERVED_NIBBLE, nextDataLowByte[3:0]}; // see RULE9
         IDX_NDATA_HIGH_MAIN: next_rdat = sameTrigHigh ? nextDataHighByte :
                                {nextDataHighByte[7:4], RESERVED_NIBBLE}; // see RULE12
         IDX_NDATA_HIGH_SPLIT: next_rdat = sameTrigHigh ? RESERVED_BYTE :
                                {RESERVED_NIBBLE, nextDataHighByte[3:0]}; // see RULE11
         default: next_rdat = RST_BYTE; // Direction register is write-only
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= 32'h00000000;
      end else if (access && !wb_we_i) begin
         wb_dat_o <= {24'h000000, next_rdat};
      end
   end

   // Pins carry both port data bytes; only pins 15..8 get an enable from direction, see RULE2
   assign patternOut = {portBOutputData, portAOutputData};
   assign portBOutEnableN = ~portBDirection; // see RULE1

endmodule

// File: design/pndr_pkg.sv
// Package for the pattern next-data register bank.
// Assumes an 8-bit register view placed on a 32-bit classic Wishbone bus.
package pndr_pkg;
   // ******************************************************
   // Register indices (byte address is four times the index)
   // ******************************************************
   localparam logic [15:0] IDX_NEXT_EN_HIGH = 16'hFFA2;
   localparam logic [15:0] IDX_NEXT_EN_LOW = 16'hFFA3;
   localparam logic [15:0] IDX_NDATA_HIGH_MAIN = 16'hFFA4;
   localparam logic [15:0] IDX_NDATA_LOW_MAIN = 16'hFFA5;
   localparam logic [15:0] IDX_NDATA_HIGH_SPLIT = 16'hFFA6;
   localparam logic [15:0] IDX_NDATA_LOW_SPLIT = 16'hFFA7;
   localparam logic [15:0] IDX_TRIG_SELECT = 16'hFFA1;
   localparam logic [15:0] IDX_PORT_A_DATA = 16'hFFD3;
   localparam logic [15:0] IDX_PORT_B_DIR = 16'hFFD4;
   localparam logic [15:0] IDX_PORT_B_DATA = 16'hFFD6;
   // ******************************************************
   // Reset values and constants
   // ******************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TRIG_SELECT = 8'hFF;
   localparam logic [3:0] RESERVED_NIBBLE = 4'hF;
   localparam logic [7:0] RESERVED_BYTE = 8'hFF;
   localparam int ADDR_LSB = 2;
endpackage

// File: verification/pndr_checker.sv
// Concurrent checks on the ports of the pattern next-data register bank.
// Assumes one clock mclk and the asynchronous active-low reset nrst.
`timescale 1ns/1ps
module pndr_checker
   import pndr_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [17:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [3:0] compareMatch,
   input wire logic [15:0] patternOut,
   input wire logic [7:0] portBOutEnableN,
   input wire logic [7:0] portAOutputData,
   input wire logic [7:0] portBOutputData
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic rdAck;
   logic [15:0] idx;
   assign rdAck = wb_ack_o && !wb_we_i;
   assign idx = wb_adr_i[17:2];
   // ************************************************
   // Properties
   // ************************************************
   property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_dir_write;
      wb_ack_o && wb_we_i && wb_sel_i[0] && idx == IDX_PORT_B_DIR
         |-> portBOutEnableN == ~wb_dat_i[7:0];
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction not applied");
   property p_dir_read; rdAck && idx == IDX_PORT_B_DIR |-> wb_dat_o == 32'h0; endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction readable");
   property p_rsv;
      rdAck && (idx == IDX_NDATA_LOW_SPLIT || idx == IDX_NDATA_HIGH_SPLIT)
         |-> wb_dat_o[7:4] == RESERVED_NIBBLE;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved nibble");
   // Quiet inputs on one edge must leave both ports alone on the next
   property p_hold;
      compareMatch == 4'h0 && !(wb_cyc_i && wb_stb_i)
         |=> $stable(portAOutputData) && $stable(portBOutputData);
   endproperty
   a_hold: assert property (p_hold) else $error("port data moved");
   property p_pattern; patternOut == {portBOutputData, portAOutputData}; endproperty
   a_pattern: assert property (p_pattern) else $error("pattern pins");
   property p_upper; rdAck |-> wb_dat_o[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits");
   c_dir: cover property (wb_ack_o && wb_we_i && idx == IDX_PORT_B_DIR);
   c_cm: cover property (compareMatch != 4'h0);
   c_rsv: cover property (rdAck && idx == IDX_NDATA_LOW_SPLIT);
endmodule
bind pndr_pattern_next_data_regs pndr_checker chk_u (.mclk(mclk), .nrst(nrst),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .compareMatch(compareMatch), .patternOut(patternOut), .portBOutEnableN(portBOutEnableN),
   .portAOutputData(portAOutputData), .portBOutputData(portBOutputData));

// File: verification/pndr_timer_model.sv
// Timer unit model: one-cycle compare-match strobes on request.
// Assumes requests from the bench last one mclk cycle.
`timescale 1ns/1ps
module pndr_timer_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] fireReq,
   output logic [3:0] compareMatch
);
   // Registered so a strobe never shares an edge with the request
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         compareMatch <= 4'h0;
      end else begin
         compareMatch <= fireReq;
      end
   end
endmodule

// File: verification/pndr_pattern_next_data_regs_test.sv
// Self-checking bench: bus reads are noted in a queue and checked on ack.
// Assumes the timer model drives compareMatch.
`timescale 1ns/1ps
module pndr_pattern_next_data_regs_test;
   import pndr_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
   logic [17:0] adr = 18'h0;
   logic [31:0] dw = 32'h0, dr;
   logic [3:0] sel = 4'h0, fireReq = 4'h0, cm;
   logic [15:0] pat;
   logic [7:0] enN, pa, pb, a, b, c;
   logic [7:0] q[$];
   int seed = 82, miscompares = 0, n_tests = 0;
   logic [15:0] rIdx [11] = '{IDX_NDATA_LOW_MAIN, IDX_NDATA_HIGH_MAIN, IDX_NDATA_LOW_SPLIT,
      IDX_NDATA_HIGH_SPLIT, IDX_NEXT_EN_LOW, IDX_NEXT_EN_HIGH, IDX_TRIG_SELECT,
      IDX_PORT_A_DATA, IDX_PORT_B_DATA, IDX_PORT_B_DIR, 16'h0010};
   logic [7:0] rVal [11] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF,
      8'h00, 8'h00, 8'h00, 8'h00};
   always #12.5 mclk = ~mclk;
   pndr_pattern_next_data_regs dut_u (.mclk(mclk), .nrst(nrst), .wb_adr_i(adr),
      .wb_dat_i(dw), .wb_dat_o(dr), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_ack_o(ack), .compareMatch(cm), .patternOut(pat),
      .portBOutEnableN(enN), .portAOutputData(pa), .portBOutputData(pb));
   pndr_timer_model tm_u (.mclk(mclk), .nrst(nrst), .fireReq(fireReq), .compareMatch(cm));
   // ************************************************
   // Tasks
   // ************************************************
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wb(input logic [15:0] i, input logic w, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hF; adr <= {i, 2'b00}; dw <= {24'h0, d};
      do @(posedge mclk); while (ack !== 1'b1);
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] d); wb(i, 1'b1, d); endtask
   task automatic rd(input logic [15:0] i, input logic [7:0] e);
      q.push_back(e);
      wb(i, 1'b0, 8'h00);
   endtask
   task automatic reset_reads();
      for (int k = 0; k < 11; k++) rd(rIdx[k], rVal[k]);
      chk("enableN", 8'hFF, enN);
      chk("pins", 8'h00, pat[7:0] | pat[15:8]);
   endtask
   task automatic fire(input int ch);
      @(posedge mclk);
      fireReq <= 4'h1 << ch;
      @(posedge mclk);
      fireReq <= 4'h0;
      repeat (3) @(posedge mclk);
   endtask
   always @(posedge mclk) if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
      chk("read data", q.pop_front(), dr[7:0]);
   // Whole run is a few hundred cycles
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      reset_reads();
      $display("test reset done");
      a = 8'($random(seed)); b = 8'($random(seed)); c = 8'($random(seed));
      wr(IDX_PORT_B_DIR, b);
      chk("enableN", ~b, enN);
      wr(IDX_NDATA_LOW_MAIN, a); wr(IDX_NDATA_HIGH_MAIN, b);
      wr(IDX_NDATA_LOW_SPLIT, ~a); wr(IDX_NDATA_HIGH_SPLIT, ~b);
      rd(IDX_NDATA_LOW_MAIN, a); rd(IDX_NDATA_LOW_SPLIT, 8'hFF);
      rd(IDX_NDATA_HIGH_MAIN, b); rd(IDX_NDATA_HIGH_SPLIT, 8'hFF);
      wr(IDX_NEXT_EN_LOW, 8'h0F); wr(IDX_NEXT_EN_HIGH, 8'hF0);
      rd(IDX_NEXT_EN_LOW, 8'h0F);
      for (int k = 0; k < 3; k++) begin
         fire(k);
         rd(IDX_PORT_A_DATA, 8'h00); rd(IDX_PORT_B_DATA, 8'h00);
      end
      fire(3);
      rd(IDX_PORT_A_DATA, a & 8'h0F);
      rd(IDX_PORT_B_DATA, b & 8'hF0);
      wr(IDX_PORT_A_DATA, 8'hFF); wr(IDX_PORT_B_DATA, 8'hFF);
      rd(IDX_PORT_A_DATA, 8'hF0 | (a & 8'h0F));
      rd(IDX_PORT_B_DATA, 8'h0F | (b & 8'hF0));
      $display("test shared done");
      wr(IDX_TRIG_SELECT, 8'hE4);
      rd(IDX_TRIG_SELECT, 8'hE4);
      rd(IDX_NDATA_LOW_MAIN, {a[7:4], 4'hF}); rd(IDX_NDATA_LOW_SPLIT, {4'hF, a[3:0]});
      rd(IDX_NDATA_HIGH_MAIN, {b[7:4], 4'hF}); rd(IDX_NDATA_HIGH_SPLIT, {4'hF, b[3:0]});
      wr(IDX_NDATA_LOW_SPLIT, c); wr(IDX_NDATA_HIGH_MAIN, c);
      rd(IDX_NDATA_LOW_SPLIT, {4'hF, c[3:0]});
      rd(IDX_NDATA_HIGH_MAIN, {c[7:4], 4'hF});
      wr(IDX_NEXT_EN_LOW, 8'hFF); wr(IDX_NEXT_EN_HIGH, 8'hFF);
      fire(0);
      rd(IDX_PORT_A_DATA, {4'hF, c[3:0]});
      fire(1);
      rd(IDX_PORT_A_DATA, {a[7:4], c[3:0]});
      fire(3);
      rd(IDX_PORT_B_DATA, {c[7:4], 4'hF});
      fire(2);
      rd(IDX_PORT_B_DATA, {c[7:4], b[3:0]});
      chk("port A data", {a[7:4], c[3:0]}, pa);
      chk("port B data", {c[7:4], b[3:0]}, pb);
      chk("pattern low", {a[7:4], c[3:0]}, pat[7:0]);
      chk("pattern high", {c[7:4], b[3:0]}, pat[15:8]);
      $display("test split done");
      @(posedge mclk);
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      reset_reads();
      $display("test second reset done");
      // Let the last read's check run before the verdict
      @(posedge mclk);
      chk("pending reads", 8'h00, 8'(q.size()));
      give_verdict();
   end
endmodule
